// ===== logic/gate_timer_pkg.sv
`default_nettype none
package gate_timer_pkg;
    localparam int CLK_HZ         = 100_000_000;
    localparam int CYC_PER_MS     = CLK_HZ / 1000;
    localparam int CYC_PER_NS_DIV = 1_000_000_000 / CLK_HZ;
    // times as printed
    localparam int GUARD_MS       = 50;
    localparam int VALID_MS       = 20;
    localparam int WINDOW_MS      = 30;
    localparam int DEBOUNCE_MS    = 20;
    localparam int READ_MS        = 100;
    localparam int TICK_MS        = 100;
    localparam int MANUAL_MAX_MS  = 10;
    localparam int COMPLETE_NS    = 100;
    // derived cycle counts
    localparam int GUARD_CYC      = GUARD_MS * CYC_PER_MS;
    localparam int VALID_CYC      = VALID_MS * CYC_PER_MS;
    localparam int WINDOW_CYC     = WINDOW_MS * CYC_PER_MS;
    localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * CYC_PER_MS;
    localparam int READ_CYC       = READ_MS * CYC_PER_MS;
    localparam int TICK_CYC       = TICK_MS * CYC_PER_MS;
    localparam int MANUAL_MAX_CYC = MANUAL_MAX_MS * CYC_PER_MS;
    localparam int COMPLETE_CYC   = (COMPLETE_NS + CYC_PER_NS_DIV - 1) / CYC_PER_NS_DIV;
    // interval code: ticks of 100 ms, 1 .. 72000
    localparam int CODE_W         = 17;
    localparam int CODE_MAX       = 72000;
    localparam int CNT_W          = 40;
    localparam int TMR_W          = 24;
    localparam logic GATE_OFF     = 1'b1;

    typedef struct packed {
        logic              done;
        logic [CODE_W-1:0] code;
    } meas_result_t;

    typedef enum logic [2:0] {
        S_HOLD, S_READ, S_GATE, S_OFF, S_IDLE, S_MANUAL
    } state_t;
endpackage
`default_nettype wire

// ===== logic/power_gating_interval_timer.sv
`timescale 1ns/10ps
`default_nettype none
module power_gating_interval_timer #(
    parameter int GUARD_CYC    = gate_timer_pkg::GUARD_CYC,
    parameter int VALID_CYC    = gate_timer_pkg::VALID_CYC,
    parameter int WINDOW_CYC   = gate_timer_pkg::WINDOW_CYC,
    parameter int DEBOUNCE_CYC = gate_timer_pkg::DEBOUNCE_CYC,
    parameter int READ_CYC     = gate_timer_pkg::READ_CYC,
    parameter int TICK_CYC     = gate_timer_pkg::TICK_CYC
) (
    input  wire logic                         clk,                    // 100 MHz
    input  wire logic                         rst_n,                  // async reset
    input  wire logic                         ce,                     // freezes state when low
    input  wire logic                         mode_select,            // pin: high timer
    input  wire logic                         task_complete_in,       // pin: completion
    input  wire logic                         interval_set_manual_on, // pin: manual level
    input  wire gate_timer_pkg::meas_result_t meas_result,            // digitizer result
    output logic                              meas_enable,            // analog chain on
    output logic                              gate_drive_n            // supply switch gate
);
    localparam int CW = gate_timer_pkg::CNT_W;
    localparam int TW = gate_timer_pkg::TMR_W;

    // window, debounce and read counters are TW bits wide; a guard as long as a tick leaves no pulse at code 1
    if (GUARD_CYC < 1 || GUARD_CYC >= TICK_CYC || VALID_CYC < 1 || VALID_CYC > WINDOW_CYC ||
        DEBOUNCE_CYC < 1 || READ_CYC < 1 || WINDOW_CYC >= (1 << TW) ||
        READ_CYC >= (1 << TW) || DEBOUNCE_CYC >= (1 << TW)) begin : g_bad_timing
        $error("power_gating_interval_timer: unsupported timing parameters");
    end

    gate_timer_pkg::state_t st_q, st_d;
    logic [2:0]    mode_sy_q;
    logic [2:0]    done_sy_q;
    logic [1:0]    man_sy_q;
    logic          man_s;
    logic          mode_q;
    logic          done_rise;
    logic          done_take;
    logic          man_valid;
    logic          man_ok;
    logic          man_db_q;
    logic          win_act_q;
    logic [TW-1:0] win_q;
    logic [TW-1:0] hi_q;
    logic [TW-1:0] lo_q;
    logic [TW-1:0] rcnt_q;
    logic [CW-1:0] icnt_q, icnt_d;
    logic [CW-1:0] int_cyc_q;
    logic [CW-1:0] on_last;
    logic [CW-1:0] int_last;
    logic          code_ok_q;
    logic          gate_n_q;
    logic          read_end;

    // pins pass two flops; third stage only for the edge detector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_sy_q <= 3'h0;
            done_sy_q <= 3'h0;
            man_sy_q  <= 2'h0;
        end else if (ce) begin
            mode_sy_q <= {mode_sy_q[1:0], mode_select};
            done_sy_q <= {done_sy_q[1:0], task_complete_in};
            man_sy_q  <= {man_sy_q[0], interval_set_manual_on};
        end
    end
    assign man_s = man_sy_q[1];

    // edge, not level; the 100 ns pulse spans many clocks
    assign done_rise = done_sy_q[1] && !done_sy_q[2];
    assign done_take = done_rise && !man_db_q && !man_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_act_q <= 1'b0;
            win_q     <= '0;
            hi_q      <= '0;
        end else if (ce) begin
            if (!win_act_q) begin
                win_act_q <= man_s && !man_db_q;
                win_q     <= '0;
                hi_q      <= TW'(man_s);
            end else if (win_q == TW'(WINDOW_CYC - 1) || man_valid) begin
                win_act_q <= 1'b0;
            end else begin
                win_q <= win_q + 1'b1;
                hi_q  <= hi_q + TW'(man_s);
            end
        end
    end
    assign man_valid = win_act_q && man_s && !man_db_q && hi_q >= TW'(VALID_CYC - 1);

    // rise needs 20 ms high, fall needs a stable low stretch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            man_db_q <= 1'b0;
            lo_q     <= '0;
        end else if (ce) begin
            if (man_valid) begin
                man_db_q <= 1'b1;
            end else if (man_db_q && !man_s && lo_q == TW'(DEBOUNCE_CYC - 1)) begin
                man_db_q <= 1'b0;
            end
            lo_q <= (man_db_q && !man_s) ? lo_q + 1'b1 : '0;
        end
    end

    // only while gate is high; not during start-up
    assign man_ok = man_valid && gate_n_q &&
                    (st_q == gate_timer_pkg::S_OFF || st_q == gate_timer_pkg::S_IDLE);

    assign read_end = rcnt_q == TW'(READ_CYC - 1);
    assign on_last  = int_cyc_q - CW'(GUARD_CYC) - 1'b1;
    assign int_last = int_cyc_q - 1'b1;

    always_comb begin
        st_d   = st_q;
        icnt_d = icnt_q + 1'b1;
        unique case (st_q)
            gate_timer_pkg::S_HOLD: begin
                if (!man_s) st_d = gate_timer_pkg::S_READ;
            end
            gate_timer_pkg::S_READ: begin
                icnt_d = '0;
                if (man_s) begin
                    st_d = gate_timer_pkg::S_HOLD;
                end else if (read_end && code_ok_q) begin
                    // first pulse starts with the interval
                    st_d = gate_timer_pkg::S_GATE;
                end
            end
            gate_timer_pkg::S_GATE: begin
                // first accepted completion ends the pulse
                // later edges land in off or idle, which ignore them
                if (done_take || icnt_q == on_last) begin
                    st_d = mode_q ? gate_timer_pkg::S_OFF : gate_timer_pkg::S_IDLE;
                end
            end
            gate_timer_pkg::S_OFF: begin
                if (man_ok) begin
                    st_d   = gate_timer_pkg::S_MANUAL;
                    icnt_d = '0;
                end else if (icnt_q == int_last) begin
                    // next falling edge one interval later
                    st_d   = gate_timer_pkg::S_GATE;
                    icnt_d = '0;
                end
            end
            gate_timer_pkg::S_IDLE: begin
                icnt_d = '0;
                if (man_ok) st_d = gate_timer_pkg::S_MANUAL;
            end
            gate_timer_pkg::S_MANUAL: begin
                icnt_d = '0;
                if (!man_db_q) st_d = gate_timer_pkg::S_GATE;
            end
            default: begin
                st_d   = gate_timer_pkg::S_HOLD;
                icnt_d = '0;
            end
        endcase
    end

    // start-up states are never re-entered after the reading
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= gate_timer_pkg::S_HOLD;
            icnt_q <= '0;
        end else if (ce) begin
            st_q   <= st_d;
            icnt_q <= icnt_d;
        end
    end

    // reading lasts 100 ms and repeats until a valid code is latched
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_q <= '0;
        end else if (ce) begin
            rcnt_q <= (st_q == gate_timer_pkg::S_READ && !read_end) ? rcnt_q + 1'b1 : '0;
        end
    end

    // latch code on strobe; zero or out-of-range codes rejected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_cyc_q <= '0;
            code_ok_q <= 1'b0;
        end else if (ce) begin
            if (st_q != gate_timer_pkg::S_READ) begin
                code_ok_q <= 1'b0;
            end else if (meas_result.done) begin
                int_cyc_q <= CW'(meas_result.code) * CW'(TICK_CYC);
                code_ok_q <= meas_result.code != '0 &&
                             meas_result.code <= gate_timer_pkg::CODE_W'(gate_timer_pkg::CODE_MAX);
            end
        end
    end

    // mode resampled every reading cycle; the value at the end of the reading is kept
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 1'b0;
        end else if (ce && st_q == gate_timer_pkg::S_READ) begin
            mode_q <= mode_sy_q[1];
        end
    end

    // low only in pulse or manual hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_n_q <= gate_timer_pkg::GATE_OFF;
        end else if (ce) begin
            gate_n_q <= !(st_d == gate_timer_pkg::S_GATE || st_d == gate_timer_pkg::S_MANUAL);
        end
    end

    assign gate_drive_n = gate_n_q;
    assign meas_enable  = st_q == gate_timer_pkg::S_READ;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_pulse_end;
        ce && st_q == gate_timer_pkg::S_GATE && !done_take && icnt_q == on_last;
    endsequence
    sequence s_done_taken;
        ce && st_q == gate_timer_pkg::S_GATE && done_take;
    endsequence
    sequence s_gate_off_after;
        gate_drive_n ##1 (gate_drive_n || !ce || st_q == gate_timer_pkg::S_GATE);
    endsequence

    chk_interval_restart: assert property (
        (ce && st_q == gate_timer_pkg::S_OFF && !man_ok && icnt_q == int_last)
        |=> !gate_drive_n && icnt_q == '0)
        else $error("gate did not go low at interval start");
    chk_guard_high: assert property (
        s_pulse_end |=> s_gate_off_after)
        else $error("gate not high through guard time");
    chk_done_turns_off: assert property (
        s_done_taken |=> gate_drive_n && st_q != gate_timer_pkg::S_GATE)
        else $error("completion did not switch gate off");
    chk_manual_ignored: assert property (
        (ce && man_valid && !gate_drive_n) |=> st_q != gate_timer_pkg::S_MANUAL)
        else $error("manual request taken while gate low");
    chk_manual_low: assert property (
        (st_q == gate_timer_pkg::S_MANUAL) |-> !gate_drive_n && icnt_q == '0)
        else $error("gate high during manual hold");
    chk_startup_quiet: assert property (
        (st_q == gate_timer_pkg::S_READ || st_q == gate_timer_pkg::S_HOLD) |-> gate_drive_n)
        else $error("gate pulse during reading");
    chk_oneshot_hold: assert property (
        (st_q == gate_timer_pkg::S_IDLE && ce && !man_ok) |=> gate_drive_n && !mode_q)
        else $error("one-shot gate left high state");
    chk_read_abort: assert property (
        (ce && st_q == gate_timer_pkg::S_READ && man_s) |=> st_q == gate_timer_pkg::S_HOLD
        ##0 !meas_enable)
        else $error("reading not aborted by manual request");
    chk_manual_fast: assert property (
        (ce && man_ok) |=> !gate_drive_n)
        else $error("gate not low after valid manual request");
    chk_late_done_dropped: assert property (
        (ce && done_rise && !man_ok && st_q == gate_timer_pkg::S_OFF && icnt_q != int_last)
        |=> gate_drive_n)
        else $error("second completion edge acted on");
    chk_done_edge_only: assert property (
        (ce && st_q == gate_timer_pkg::S_GATE && icnt_q != on_last && !done_rise)
        |=> st_q == gate_timer_pkg::S_GATE)
        else $error("pulse ended without completion edge");
endmodule
`default_nettype wire

// ===== tb/mcu_model.sv
`timescale 1ns/10ps
`default_nettype none
module mcu_model (
    input  wire logic        clk,              // bench clock
    input  wire logic        gate_drive_n,     // supply on while low
    input  wire logic [15:0] done_delay,       // powered cycles to completion, 0 never
    input  wire logic        stuck_high,       // faulty processor holding a level
    output logic             task_complete_in  // completion pin
);
    int unsigned on_cnt;
    int unsigned hi_cnt;

    initial begin
        on_cnt = 0;
        hi_cnt = 0;
        task_complete_in = 1'b0;
    end

    // unpowered processor cannot drive its pin, so it reads low unless stuck_high forces it high
    // pulse held 12 cycles
    always @(negedge clk) begin
        if (gate_drive_n !== 1'b0) on_cnt = 0;
        else on_cnt = on_cnt + 1;
        if (done_delay != 16'h0000 && on_cnt == done_delay) hi_cnt = 12;
        else if (hi_cnt != 0) hi_cnt = hi_cnt - 1;
        task_complete_in = stuck_high || (hi_cnt != 0 && gate_drive_n === 1'b0);
    end
endmodule
`default_nettype wire

// ===== tb/power_gating_interval_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module power_gating_interval_timer_tb;
    localparam int GUARD = 5;
    localparam int VALID = 20;
    localparam int DEBNC = 20;
    localparam int READ  = 100;
    localparam int TICK  = 100;
    logic                         clk;
    logic                         rst_n;
    logic                         mode_select;
    logic                         manual_on;
    logic                         meas_enable;
    logic                         gate_drive_n;
    logic                         task_complete_in;
    logic                         stuck_high;
    logic [15:0]                  done_delay;
    gate_timer_pkg::meas_result_t meas_result;
    int                           n_errors;
    int                           total_checks;
    int                           a;
    int                           b;

    power_gating_interval_timer #(
        .GUARD_CYC   (GUARD),
        .VALID_CYC   (VALID),
        .WINDOW_CYC  (30),
        .DEBOUNCE_CYC(DEBNC),
        .READ_CYC    (READ),
        .TICK_CYC    (TICK)
    ) power_gating_interval_timer_inst (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .ce                    (1'b1),
        .mode_select           (mode_select),
        .task_complete_in      (task_complete_in),
        .interval_set_manual_on(manual_on),
        .meas_result           (meas_result),
        .meas_enable           (meas_enable),
        .gate_drive_n          (gate_drive_n)
    );

    mcu_model mcu_model_inst (
        .clk             (clk),
        .gate_drive_n    (gate_drive_n),
        .done_delay      (done_delay),
        .stuck_high      (stuck_high),
        .task_complete_in(task_complete_in)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic wait_gate(input logic lvl, input int max, output int cyc);
        cyc = 0;
        while (gate_drive_n !== lvl && cyc < max) begin
            @(negedge clk);
            cyc++;
        end
    endtask

    // mode pin stays fixed for the whole run after each reset
    task automatic do_reset(input logic mode);
        rst_n = 1'b0;
        mode_select = mode;
        manual_on = 1'b0;
        done_delay = 16'h0000;
        stuck_high = 1'b0;
        repeat (3) @(negedge clk);
        check("gate_in_reset", 1, gate_drive_n);
        rst_n = 1'b1;
    endtask

    // digitizer: one strobe ten cycles into the reading
    task automatic run_reading(input int code, output int len, output int lows);
        a = 0;
        while (meas_enable !== 1'b1 && a < 50) begin
            @(negedge clk);
            a++;
        end
        len = 0;
        lows = 0;
        while (meas_enable === 1'b1 && len < 1000) begin
            meas_result.done = (len == 10);
            meas_result.code = 17'(code);
            lows += (gate_drive_n !== 1'b1);
            @(negedge clk);
            len++;
        end
        meas_result.done = 1'b0;
    endtask

    task automatic t_timer();
        int x;
        int y;
        do_reset(1'b1);
        run_reading(3, x, y);
        check("read_len", READ, x);
        check("gate_low_in_read", 0, y);
        wait_gate(1'b0, 3, x);
        check("first_fall", 1, x <= 1);
        wait_gate(1'b1, 400, x);
        check("low_no_done", 3 * TICK - GUARD, x);
        // level rises while the gate is high, so the next pulse sees no edge
        stuck_high = 1'b1;
        wait_gate(1'b0, 100, y);
        check("guard_high", GUARD, y);
        wait_gate(1'b1, 400, x);
        check("level_ignored", 3 * TICK - GUARD, x);
        stuck_high = 1'b0;
        done_delay = 16'h0032;
        wait_gate(1'b0, 100, y);
        check("period", 3 * TICK, x + y);
        wait_gate(1'b1, 400, x);
        check("done_cut", 1, x >= 50 && x <= 60);
        wait_gate(1'b0, 400, y);
        check("done_period", 3 * TICK, x + y);
    endtask

    task automatic t_manual();
        int x;
        done_delay = 16'h0014;
        wait_gate(1'b1, 400, x);
        manual_on = 1'b1;
        repeat (10) @(negedge clk);
        manual_on = 1'b0;
        wait_gate(1'b0, 60, x);
        check("glitch_ignored", 60, x);
        manual_on = 1'b1;
        wait_gate(1'b0, 60, x);
        check("manual_latency", 1, x >= VALID && x <= VALID + 10);
        x = 0;
        repeat (60) begin
            @(negedge clk);
            x += (gate_drive_n === 1'b0);
        end
        check("held_low_done_ignored", 60, x);
        done_delay = 16'h0000;
        manual_on = 1'b0;
        wait_gate(1'b1, 500, x);
        check("restart_len", 1, x >= DEBNC + 290 && x <= DEBNC + 310);
        check("no_second_read", 0, meas_enable);
    endtask

    task automatic t_one_shot();
        int x;
        int y;
        do_reset(1'b0);
        x = 0;
        while (meas_enable !== 1'b1 && x < 50) begin
            @(negedge clk);
            x++;
        end
        repeat (30) @(negedge clk);
        manual_on = 1'b1;
        repeat (5) @(negedge clk);
        check("read_aborted", 0, meas_enable);
        repeat (40) @(negedge clk);
        check("no_pulse_in_abort", 1, gate_drive_n);
        manual_on = 1'b0;
        run_reading(2, x, y);
        check("read_restart", READ, x);
        wait_gate(1'b1, 400, x);
        check("one_shot_len", 2 * TICK - GUARD, x);
        wait_gate(1'b0, 600, x);
        check("single_pulse", 600, x);
        done_delay = 16'h0050;
        manual_on = 1'b1;
        wait_gate(1'b0, 60, x);
        check("manual_fall", 1, x <= VALID + 10);
        repeat (5) @(negedge clk);
        manual_on = 1'b0;
        wait_gate(1'b1, 400, x);
        check("manual_pulse_done", 1, x >= 65 && x <= 90);
        wait_gate(1'b0, 600, x);
        check("one_pulse_per_request", 600, x);
        check("no_second_read", 0, meas_enable);
    endtask

    initial begin
        n_errors = 0;
        total_checks = 0;
        rst_n = 1'b0;
        mode_select = 1'b1;
        manual_on = 1'b0;
        done_delay = 16'h0000;
        stuck_high = 1'b0;
        meas_result = '0;
        @(negedge clk);
        t_timer();
        t_manual();
        t_one_shot();
        finish_test();
    end

    // whole run needs about 3200 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("BAD watchdog expected finish seen timeout");
        finish_test();
    end
endmodule
`default_nettype wire
